// >>> ppw_port.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ppw_port (
    input wire logic mclk,
    input wire logic nrst,
    input wire ppw_pkg::ppw_bus_s bus,
    output logic [7:0] rdata,
    input wire logic [7:0] pad_in,
    output ppw_pkg::ppw_pad_s pad,
    output logic [5:0] drive_level,
    input wire logic timer2_pwm_out,
    input wire logic pwm_gen_a_out,
    input wire logic pwm_gen_b_out,
    input wire logic pwm_gen_c_out,
    input wire logic comparator_out,
    input wire logic asleep,
    output logic wake_req,
    output logic wake_fast,
    output logic hw_reset_req,
    output logic ext_int_req,
    output logic irq
);
    logic [7:0] data_out;
    logic [7:0] direction;
    logic [7:0] pin_digital_input_enable;
    logic [7:0] pull_en;
    logic [7:0] pull_high;
    logic [7:0] wake_en;
    logic [7:0] wake_speed_fast;
    logic [7:0] int_edge;
    logic [7:0] alt_sel;
    logic [5:0] drive;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [7:0] pin_sync;
    logic [7:0] pin_prev;
    logic [7:0] pin_level;
    logic [7:0] wake_hits;
    logic ext_edge;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [7:0] next_out;
    logic [7:0] next_oe;
    logic [1:0] arm_cnt;
    logic edges_armed;
    ppw_pkg::ppw_alt_e sel0, sel3, sel4, sel5;

    function automatic ppw_pkg::ppw_alt_e alt_of(input logic [7:0] sel, input int pos);
        alt_of = ppw_pkg::ppw_alt_e'(sel[pos +: 2]);
    endfunction : alt_of

    function automatic logic wr_hit(input ppw_pkg::ppw_bus_s b, input logic [3:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction : wr_hit

    assign sel0 = alt_of(alt_sel, ppw_pkg::ALT_POS_BIT0);
    assign sel3 = alt_of(alt_sel, ppw_pkg::ALT_POS_BIT3);
    assign sel4 = alt_of(alt_sel, ppw_pkg::ALT_POS_BIT4);
    assign sel5 = alt_of(alt_sel, ppw_pkg::ALT_POS_BIT5);

    // control registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_out <= ppw_pkg::RST_DATA_OUT;
            direction <= ppw_pkg::RST_DIRECTION;
            pin_digital_input_enable <= ppw_pkg::RST_DIG_IN_EN;
            pull_en <= ppw_pkg::RST_PULL_EN;
            pull_high <= ppw_pkg::RST_PULL_HIGH;
            wake_en <= ppw_pkg::RST_WAKE_EN;
            wake_speed_fast <= ppw_pkg::RST_WAKE_FAST;
            int_edge <= ppw_pkg::RST_INT_EDGE;
            alt_sel <= ppw_pkg::RST_ALT_SEL;
            drive <= ppw_pkg::RST_DRIVE;
            irq_enable <= ppw_pkg::RST_IRQ;
        end else begin
            if (wr_hit(bus, ppw_pkg::ADDR_DATA_OUT)) data_out <= bus.wdata & ppw_pkg::PIN_MASK;
            if (wr_hit(bus, ppw_pkg::ADDR_DIRECTION)) direction <= bus.wdata & ppw_pkg::PIN_MASK;
            if (wr_hit(bus, ppw_pkg::ADDR_DIG_IN_EN)) begin
                pin_digital_input_enable <= bus.wdata & ppw_pkg::PIN_MASK;
            end
            if (wr_hit(bus, ppw_pkg::ADDR_PULL_EN)) pull_en <= bus.wdata & ppw_pkg::PIN_MASK;
            if (wr_hit(bus, ppw_pkg::ADDR_PULL_HIGH)) pull_high <= bus.wdata & ppw_pkg::PIN_MASK;
            if (wr_hit(bus, ppw_pkg::ADDR_WAKE_EN)) wake_en <= bus.wdata & ppw_pkg::PIN_MASK;
            if (wr_hit(bus, ppw_pkg::ADDR_WAKE_FAST)) begin
                wake_speed_fast <= bus.wdata & ppw_pkg::PIN_MASK;
            end
            if (wr_hit(bus, ppw_pkg::ADDR_INT_EDGE)) int_edge <= {7'h00, bus.wdata[0]};
            if (wr_hit(bus, ppw_pkg::ADDR_ALT_SEL)) alt_sel <= bus.wdata;
            if (wr_hit(bus, ppw_pkg::ADDR_DRIVE)) drive <= bus.wdata[5:0];
            if (wr_hit(bus, ppw_pkg::ADDR_IRQ_ENABLE)) irq_enable <= bus.wdata[1:0];
        end
    end

    // input path: sync then gate by input enable
    ppw_sync2 #(.WIDTH(8)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d(pad_in),
        .q(pin_sync)
    );

    assign pin_level = pin_sync & pin_digital_input_enable & ppw_pkg::PIN_MASK;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_prev <= 8'h00;
        end else begin
            pin_prev <= pin_level;
        end
    end

    // no edges until sync and prev flops hold real pin levels
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            arm_cnt <= 2'h0;
        end else if (!edges_armed) begin
            arm_cnt <= arm_cnt + 2'h1;
        end
    end

    assign edges_armed = (arm_cnt == 2'(ppw_pkg::SYNC_STAGES + 1));

    // edge on bit 0, polarity chosen by int_edge[0]
    assign ext_edge = edges_armed && (int_edge[0]
        ? (pin_prev[ppw_pkg::INT_PIN] & ~pin_level[ppw_pkg::INT_PIN])
        : (~pin_prev[ppw_pkg::INT_PIN] & pin_level[ppw_pkg::INT_PIN]));

    // any toggle on an enabled, digitally enabled pin while asleep
    assign wake_hits = (pin_prev ^ pin_level) & wake_en & pin_digital_input_enable
                       & ppw_pkg::PIN_MASK & {8{edges_armed}};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_req <= 1'b0;
            wake_fast <= 1'b0;
            ext_int_req <= 1'b0;
        end else begin
            wake_req <= asleep && (wake_hits != 8'h00);
            wake_fast <= asleep && ((wake_hits & wake_speed_fast) != 8'h00);
            ext_int_req <= ext_edge;
        end
    end

    // sticky status, set beats clear
    assign irq_set = {asleep && (wake_hits != 8'h00), ext_edge};
    assign irq_clr = wr_hit(bus, ppw_pkg::ADDR_IRQ_CLEAR) ? bus.wdata[1:0] : 2'h0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= ppw_pkg::RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq = (irq_status & irq_enable) != 2'h0;

    // output mux
    always_comb begin
        next_out = data_out;
        next_oe = direction & ppw_pkg::PIN_MASK;
        unique case (sel0)
            ppw_pkg::ALT_FUNC_A: begin
                next_out[0] = comparator_out;
                next_oe[0] = 1'b1;
            end
            ppw_pkg::ALT_FUNC_B: begin
                next_out[0] = pwm_gen_a_out;
                next_oe[0] = 1'b1;
            end
            default: begin
            end
        endcase
        unique case (sel3)
            ppw_pkg::ALT_FUNC_A: begin
                next_out[3] = timer2_pwm_out;
                next_oe[3] = 1'b1;
            end
            ppw_pkg::ALT_FUNC_B: begin
                next_out[3] = pwm_gen_c_out;
                next_oe[3] = 1'b1;
            end
            default: begin
            end
        endcase
        unique case (sel4)
            ppw_pkg::ALT_FUNC_A: begin
                next_out[4] = timer2_pwm_out;
                next_oe[4] = 1'b1;
            end
            ppw_pkg::ALT_FUNC_B: begin
                next_out[4] = pwm_gen_b_out;
                next_oe[4] = 1'b1;
            end
            default: begin
            end
        endcase
        unique case (sel5)
            ppw_pkg::ALT_FUNC_A: begin
                next_out[5] = pwm_gen_c_out;
                next_oe[5] = 1'b1;
            end
            ppw_pkg::ALT_FUNC_B: begin
                next_out[5] = 1'b0;
                next_oe[5] = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pad <= '{out: 8'h00, oe: 8'h00, pull_up: 8'h00, pull_down: 8'h00,
                     input_en: ppw_pkg::RST_DIG_IN_EN};
            drive_level <= ppw_pkg::RST_DRIVE;
            hw_reset_req <= 1'b0;
        end else begin
            pad.out <= next_out;
            pad.oe <= next_oe;
            pad.pull_up <= pull_en & pull_high & ppw_pkg::PIN_MASK;
            pad.pull_down <= pull_en & ~pull_high & ppw_pkg::PIN_MASK;
            pad.input_en <= pin_digital_input_enable;
            drive_level <= drive;
            hw_reset_req <= (sel5 == ppw_pkg::ALT_FUNC_B) && !pin_sync[5];
        end
    end

    // read port, data the cycle after the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ppw_pkg::ADDR_DATA_OUT: rdata <= data_out;
                ppw_pkg::ADDR_DIRECTION: rdata <= direction;
                ppw_pkg::ADDR_DIG_IN_EN: rdata <= pin_digital_input_enable;
                ppw_pkg::ADDR_PULL_EN: rdata <= pull_en;
                ppw_pkg::ADDR_PULL_HIGH: rdata <= pull_high;
                ppw_pkg::ADDR_WAKE_EN: rdata <= wake_en;
                ppw_pkg::ADDR_WAKE_FAST: rdata <= wake_speed_fast;
                ppw_pkg::ADDR_INT_EDGE: rdata <= int_edge;
                ppw_pkg::ADDR_ALT_SEL: rdata <= alt_sel;
                ppw_pkg::ADDR_DRIVE: rdata <= {2'h0, drive};
                ppw_pkg::ADDR_PIN_LEVEL: rdata <= pin_level;
                ppw_pkg::ADDR_IRQ_STATUS: rdata <= {6'h00, irq_status};
                ppw_pkg::ADDR_IRQ_ENABLE: rdata <= {6'h00, irq_enable};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_rise0;
        !pin_level[0] ##1 pin_level[0];
    endsequence

    sequence s_pad_change;
        $changed(pad_in[0]) && pin_digital_input_enable[0] && int_edge[0] == 1'b0;
    endsequence

    pull_exclusive_a: assert property ((pad.pull_up & pad.pull_down) == 8'h00)
        else $error("pull-high and pull-low both on");

    dir_input_a: assert property (
        ((pad.oe & ~$past(direction)) & ppw_pkg::FIXED_PIN_MASK) == 8'h00)
        else $error("crystal-side pin driven while set as input");

    input_blocked_a: assert property (bus.rd && bus.addr == ppw_pkg::ADDR_PIN_LEVEL |=>
        (rdata & ~$past(pin_digital_input_enable)) == 8'h00)
        else $error("disabled pin reaches digital input");

    wake_gated_a: assert property (wake_req |-> $past(asleep)
        && ($past((pin_prev ^ pin_level) & wake_en & pin_digital_input_enable) != 8'h00))
        else $error("wake without enabled pin toggle while asleep");

    int_rise_a: assert property (s_rise0 ##0 (edges_armed && int_edge[0] == 1'b0)
        |-> ##1 irq_status[0])
        else $error("rising edge on bit 0 not latched");

    int_sync_lat_a: assert property (s_pad_change
        ##1 (pin_digital_input_enable[0] && !int_edge[0] && !asleep) [*3]
        |-> ($past(pin_level[0]) != $past(pin_level[0], 2)))
        else $error("input edge not seen after two sync stages");

    wake_fast_a: assert property (wake_fast |-> wake_req)
        else $error("fast wake without wake request");

    gen_a_route_a: assert property ($past(sel0) == ppw_pkg::ALT_FUNC_B |->
        pad.out[0] == $past(pwm_gen_a_out) && pad.oe[0])
        else $error("bit 0 not carrying generator a");

    drive_write_a: assert property (wr_hit(bus, ppw_pkg::ADDR_DRIVE) |->
        ##2 drive_level == $past(bus.wdata[5:0], 2))
        else $error("drive level not applied two cycles after write");

    irq_level_a: assert property (irq == ((irq_status & irq_enable) != 2'h0))
        else $error("interrupt output disagrees with enabled status");
endmodule : ppw_port
`default_nettype wire

// >>> ppw_pkg.sv
`default_nettype none
package ppw_pkg;
    // register offsets on the plain software port
    localparam logic [3:0] ADDR_DATA_OUT = 4'h0;
    localparam logic [3:0] ADDR_DIRECTION = 4'h1;
    localparam logic [3:0] ADDR_DIG_IN_EN = 4'h2;
    localparam logic [3:0] ADDR_PULL_EN = 4'h3;
    localparam logic [3:0] ADDR_PULL_HIGH = 4'h4;
    localparam logic [3:0] ADDR_WAKE_EN = 4'h5;
    localparam logic [3:0] ADDR_WAKE_FAST = 4'h6;
    localparam logic [3:0] ADDR_INT_EDGE = 4'h7;
    localparam logic [3:0] ADDR_ALT_SEL = 4'h8;
    localparam logic [3:0] ADDR_DRIVE = 4'h9;
    localparam logic [3:0] ADDR_PIN_LEVEL = 4'ha;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'hb;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'hc;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hd;

    // bits 0,3,4,5,6,7 exist; bits 2:1 read zero
    localparam logic [7:0] PIN_MASK = 8'hf9;
    localparam logic [7:0] FIXED_PIN_MASK = 8'hc0;

    localparam logic [7:0] RST_DATA_OUT = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_DIG_IN_EN = 8'hf9;
    localparam logic [7:0] RST_PULL_EN = 8'h00;
    localparam logic [7:0] RST_PULL_HIGH = 8'h00;
    localparam logic [7:0] RST_WAKE_EN = 8'h00;
    localparam logic [7:0] RST_WAKE_FAST = 8'h00;
    localparam logic [7:0] RST_INT_EDGE = 8'h00;
    localparam logic [7:0] RST_ALT_SEL = 8'h00;
    localparam logic [5:0] RST_DRIVE = 6'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // field positions
    localparam int INT_PIN = 0;
    localparam int ALT_POS_BIT0 = 0;
    localparam int ALT_POS_BIT3 = 2;
    localparam int ALT_POS_BIT4 = 4;
    localparam int ALT_POS_BIT5 = 6;
    localparam int IRQ_EXT = 0;
    localparam int IRQ_WAKE = 1;
    localparam int SYNC_STAGES = 2;

    // two-bit alternate select per muxed pin
    typedef enum logic [1:0] {
        ALT_GPIO = 2'h0,
        ALT_FUNC_A = 2'h1,
        ALT_FUNC_B = 2'h2,
        ALT_RSVD = 2'h3
    } ppw_alt_e;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] input_en;
    } ppw_pad_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppw_bus_s;
endpackage : ppw_pkg
`default_nettype wire

// >>> ppw_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module ppw_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ppw_sync2
`default_nettype wire

// >>> ppw_board.sv
`timescale 1ns/1ps
`default_nettype none
module ppw_board (
    input wire logic mclk,
    input wire ppw_pkg::ppw_pad_s pad,
    input wire logic [7:0] board_val,
    input wire logic [7:0] board_en,
    output logic [7:0] pad_in
);
    // released, unpulled pins wander every cycle
    logic [7:0] float_q = 8'h00;
    always @(posedge mclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad.oe[i]) pad_in[i] = pad.out[i];
            else if (board_en[i]) pad_in[i] = board_val[i];
            else if (pad.pull_up[i]) pad_in[i] = 1'b1;
            else if (pad.pull_down[i]) pad_in[i] = 1'b0;
            else pad_in[i] = float_q[i];
        end
    end
endmodule : ppw_board
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, nrst, asleep, rd_d;
    ppw_pkg::ppw_bus_s bus;
    ppw_pkg::ppw_pad_s pad;
    logic [7:0] rdata, pad_in, board_val, board_en, v, w;
    logic [5:0] drive_level;
    logic [4:0] src;
    logic wake_req, wake_fast, hw_reset_req, ext_int_req, irq;
    logic [7:0] exp_q[$];
    int errors, checked, n_int, n_wake, n_fast, first_int;

    ppw_port i_ppw_port (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .pad_in(pad_in), .pad(pad), .drive_level(drive_level), .timer2_pwm_out(src[4]),
        .pwm_gen_a_out(src[3]), .pwm_gen_b_out(src[2]), .pwm_gen_c_out(src[1]),
        .comparator_out(src[0]), .asleep(asleep), .wake_req(wake_req),
        .wake_fast(wake_fast), .hw_reset_req(hw_reset_req), .ext_int_req(ext_int_req),
        .irq(irq));
    ppw_board i_ppw_board (.mclk(mclk), .pad(pad), .board_val(board_val),
        .board_en(board_en), .pad_in(pad_in));

    always #50 mclk = ~mclk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d, checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        exp_q.push_back(exp);
        @(posedge mclk);
        bus.rd <= 1'b0;
    endtask : rd

    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_d) chk(rdata, exp_q.pop_front());
        rd_d <= bus.rd;
    end

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic pin(input int i, input logic b);
        @(posedge mclk);
        board_val[i] <= b;
    endtask : pin

    task automatic watch();
        n_int = 0;
        n_wake = 0;
        n_fast = 0;
        first_int = 0;
        for (int i = 1; i <= 8; i++) begin
            settle(1);
            if (ext_int_req === 1'b1 && first_int == 0) first_int = i;
            if (ext_int_req === 1'b1) n_int++;
            if (wake_req === 1'b1) n_wake++;
            if (wake_req === 1'b1 && wake_fast === 1'b1) n_fast++;
        end
    endtask : watch

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        end_sim();
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        bus = '0;
        src = '0;
        asleep = 1'b0;
        board_val = 8'h00;
        board_en = 8'hff;
        rd_d = 1'b0;
        errors = 0;
        checked = 0;
        void'($urandom(32'h102376e3));
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        chk(pad.input_en, ppw_pkg::RST_DIG_IN_EN);
        for (int a = 0; a < 16; a++) begin
            if (a != 10) rd(4'(a), (a == 2) ? ppw_pkg::RST_DIG_IN_EN : 8'h00);
        end
        for (int a = 0; a < 10; a++) begin
            v = 8'($urandom);
            w = (a == 8) ? 8'hff : (a == 9) ? 8'h3f : ppw_pkg::PIN_MASK;
            if (a != 7) wr(4'(a), v);
            if (a != 7) rd(4'(a), v & w);
        end
        wr(ppw_pkg::ADDR_IRQ_CLEAR, 8'h03);
        wr(ppw_pkg::ADDR_IRQ_STATUS, 8'hff);
        rd(ppw_pkg::ADDR_IRQ_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = {2'h0, 2'(i), 2'(3 - i), 2'(i ^ 1)};
            wr(ppw_pkg::ADDR_DRIVE, v);
            settle(1);
            chk(8'(drive_level), v);
        end
        v = 8'($urandom);
        w = 8'($urandom);
        wr(ppw_pkg::ADDR_ALT_SEL, 8'h00);
        wr(ppw_pkg::ADDR_DIG_IN_EN, 8'hf9);
        wr(ppw_pkg::ADDR_DIRECTION, v);
        wr(ppw_pkg::ADDR_DATA_OUT, w);
        @(posedge mclk);
        board_val <= ~w;
        settle(4);
        chk(pad.oe, v & ppw_pkg::PIN_MASK);
        chk(pad.out & v & ppw_pkg::PIN_MASK, w & v & ppw_pkg::PIN_MASK);
        rd(ppw_pkg::ADDR_PIN_LEVEL, ~(w ^ v) & ppw_pkg::PIN_MASK);
        v = 8'($urandom) & 8'h3f;
        wr(ppw_pkg::ADDR_DIG_IN_EN, v);
        wr(ppw_pkg::ADDR_DIRECTION, 8'h00);
        @(posedge mclk);
        board_val <= 8'hff;
        settle(4);
        chk(pad.input_en, v & ppw_pkg::PIN_MASK);
        rd(ppw_pkg::ADDR_PIN_LEVEL, v & ppw_pkg::PIN_MASK);
        v = 8'($urandom);
        wr(ppw_pkg::ADDR_DIG_IN_EN, 8'hf9);
        wr(ppw_pkg::ADDR_PULL_EN, 8'hff);
        wr(ppw_pkg::ADDR_PULL_HIGH, v);
        @(posedge mclk);
        board_en <= 8'h06;
        settle(4);
        chk(pad.pull_up, v & ppw_pkg::PIN_MASK);
        chk(pad.pull_down, ~v & ppw_pkg::PIN_MASK);
        rd(ppw_pkg::ADDR_PIN_LEVEL, v & ppw_pkg::PIN_MASK);
        @(posedge mclk);
        board_en <= 8'hff;
        wr(ppw_pkg::ADDR_DIRECTION, 8'hff);
        wr(ppw_pkg::ADDR_DATA_OUT, 8'h00);
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            src <= 5'($urandom);
            wr(ppw_pkg::ADDR_ALT_SEL, {1'b0, 1'(s), 2'(s), 2'(s), 2'(s)});
            settle(3);
            w = 8'h00;
            if (s == 1) w = {2'h0, src[1], src[4], src[4], 2'h0, src[0]};
            if (s == 2) w = {3'h0, src[2], src[1], 2'h0, src[3]};
            if (s == 3) w = {2'h0, src[1], 5'h00};
            chk(pad.out & 8'h39, w);
        end
        wr(ppw_pkg::ADDR_DIRECTION, 8'h00);
        wr(ppw_pkg::ADDR_ALT_SEL, 8'h80);
        pin(5, 1'b0);
        settle(5);
        chk(8'(hw_reset_req), 8'h01);
        pin(5, 1'b1);
        settle(5);
        chk(8'(hw_reset_req), 8'h00);
        wr(ppw_pkg::ADDR_ALT_SEL, 8'h00);
        pin(0, 1'b0);
        wr(ppw_pkg::ADDR_IRQ_ENABLE, 8'h01);
        for (int e = 0; e < 2; e++) begin
            wr(ppw_pkg::ADDR_INT_EDGE, 8'(e));
            settle(4);
            wr(ppw_pkg::ADDR_IRQ_CLEAR, 8'h03);
            pin(0, 1'b1);
            watch();
            chk(8'(n_int), 8'(1 - e));
            pin(0, 1'b0);
            watch();
            chk(8'(n_int), 8'(e));
            chk(8'(irq), 8'h01);
            rd(ppw_pkg::ADDR_IRQ_STATUS, 8'h01);
        end
        chk(8'(first_int), 8'h03);
        wr(ppw_pkg::ADDR_IRQ_ENABLE, 8'h00);
        settle(1);
        chk(8'(irq), 8'h00);
        wr(ppw_pkg::ADDR_IRQ_CLEAR, 8'h01);
        rd(ppw_pkg::ADDR_IRQ_STATUS, 8'h00);
        @(posedge mclk);
        asleep <= 1'b1;
        wr(ppw_pkg::ADDR_WAKE_EN, 8'h08);
        wr(ppw_pkg::ADDR_WAKE_FAST, 8'h08);
        wr(ppw_pkg::ADDR_IRQ_ENABLE, 8'h02);
        for (int f = 1; f >= 0; f--) begin
            pin(3, ~1'(f));
            watch();
            chk(8'(n_wake), 8'h01);
            chk(8'(n_fast), 8'(f));
            wr(ppw_pkg::ADDR_WAKE_FAST, 8'h00);
        end
        chk(8'(irq), 8'h01);
        rd(ppw_pkg::ADDR_IRQ_STATUS, 8'h02);
        wr(ppw_pkg::ADDR_DIG_IN_EN, 8'hf1);
        pin(3, 1'b0);
        watch();
        chk(8'(n_wake), 8'h00);
        pin(4, 1'b0);
        watch();
        chk(8'(n_wake), 8'h00);
        settle(4);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
